//--- rtl/ddc_consts.svh
// Register offsets, field positions, reset values and timing counts of the downconversion path
`ifndef DDC_CONSTS_SVH
`define DDC_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_PATH_MODE 8'h50
`define OFS_DITHER 8'h51
`define OFS_FREQ0 8'h52
`define OFS_FREQ1 8'h53
`define OFS_FREQ2 8'h54
`define OFS_FREQ3 8'h55
`define OFS_PHASE_LO 8'h56
`define OFS_PHASE_HI 8'h57
`define OFS_SYNC_CTL 8'h58
`define OFS_LL_SELECT 8'h5a
`define OFS_OUT_FORMAT 8'h5b
`define OFS_STATUS 8'h5c
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define DITH_AMP_BIT 1
`define DITH_PHASE_BIT 2
`define SYNC_EN_BIT 0
`define SYNC_EVERY_BIT 1
`define LL_SEL_BIT 0
`define FMT_OFFSET_BIN_BIT 0
`define MODE_LOW_LATENCY 8'hb0
`define MODE_HIGH_PERF 8'ha0
`define FS4_WORD 32'h40000000
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define RST_PATH_MODE 8'hb0
`define RST_LL_SELECT 8'h01
`define RST_ZERO8 8'h00
`define LFSR_SEED 16'hace1
`define IN_POS_FULL 16'sh1fff
`define IN_NEG_FULL 16'she000
`define OUT_POS_FULL 14'h1fff
`define OUT_NEG_FULL 14'h2000
`define OVR_LATENCY 10
`endif

//--- rtl/ddc_nco_path.sv
// Dual channel tuning NCO, image filter, fs/4 output NCO and output coding
`timescale 1ns/10ps
`default_nettype none
`include "ddc_consts.svh"

// Functional notes
// - Overrange flag per channel appears ten sample clocks after the input event.
// - Offset binary: 0x0000 at -FS, 0x2000 at zero, 0x3fff at +FS, saturating.
// - Two's complement is the reset default; flag only beyond span.
// - Data clock output drives alongside data; capture logic latches words with it.
// - One tuning oscillator and its sine/cosine serve both channels.
// - 32-bit complex tuning NCO always runs, no bypass, outputs I and Q.
// - Frequency word built from four byte registers tuning_frequency_byte0 to tuning_frequency_byte3.
// - Frequency word is signed: 0x80000000 is -fs/2, zero is dc.
// - Two path modes: low latency (default) or high performance filter.
// - Fixed filter suppresses negative frequency images before real output.
// - Fixed fs/4 oscillator shifts to fs/4 and emits only the real part.
// - Sync control bits at sync_policy_control choose every sync or first after write.
// - Accepted sync reloads the phase accumulator with the phase offset.
// - Amplitude and phase dither enables are bits 1 and 2 of oscillator_dither_control.
// - Amplitude dither randomises sine/cosine amplitude quantisation error.
// - 0xb0 at 0x50 selects low latency; 0x5a bit 0 selects fixed NCO.
// - 0xa0 at 0x50 selects the high performance filter mode.
module ddc_nco_path (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire ddc_pkg::reg_req_t bus_i,
	output logic [7:0] rdata_o,
	input wire logic [1:0][15:0] samples_i,
	input wire logic sync_i,
	output logic [13:0] data_o,
	output logic data_capture_clock_out_o,
	output logic [1:0] overrange_o
);
	import ddc_pkg::*;

	state_t s_r;
	state_t s_nxt;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function automatic logic [13:0] sat14(input logic signed [18:0] v);
		logic [13:0] r;
		r = v[13:0];
		if (v > 19'sh01fff) begin
			r = `OUT_POS_FULL;
		end else if (v < -19'sh02000) begin
			r = `OUT_NEG_FULL;
		end
		return r;
	endfunction : sat14

	// Quarter-wave table, midpoint samples, amplitude 2047
	function automatic logic signed [11:0] sine6(input logic [5:0] p);
		logic [3:0] idx;
		logic [11:0] m;
		idx = p[4] ? ~p[3:0] : p[3:0];
		case (idx)
			4'h0: m = 12'h064;
			4'h1: m = 12'h12c;
			4'h2: m = 12'h1f1;
			4'h3: m = 12'h2b2;
			4'h4: m = 12'h36b;
			4'h5: m = 12'h41c;
			4'h6: m = 12'h4c3;
			4'h7: m = 12'h55e;
			4'h8: m = 12'h5ec;
			4'h9: m = 12'h66c;
			4'ha: m = 12'h6db;
			4'hb: m = 12'h73a;
			4'hc: m = 12'h787;
			4'hd: m = 12'h7c1;
			4'he: m = 12'h7e9;
			default: m = 12'h7fd;
		endcase
		return p[5] ? -$signed(m) : $signed(m);
	endfunction : sine6

	// Short symmetric lowpass; stands in for the fixed coefficient sets
	function automatic logic [13:0] fir(input logic hp, input logic [13:0] x,
			input logic [3:0][13:0] h);
		logic signed [18:0] a;
		a = 19'sh0;
		if (hp) begin
			a = $signed(x) + 19'sd4 * $signed(h[0]) + 19'sd6 * $signed(h[1])
				+ 19'sd4 * $signed(h[2]) + $signed(h[3]);
			a = a >>> 4;
		end else begin
			a = $signed(x) + 19'sd2 * $signed(h[0]) + $signed(h[1]);
			a = a >>> 2;
		end
		return sat14(a);
	endfunction : fir

	// ----------------------------------------
	// Shared tuning oscillator
	// ----------------------------------------
	logic hp_mode;
	logic fixed_nco;
	logic [31:0] eff_freq;
	logic [31:0] dith_phase;
	logic [31:0] ph_sum;
	logic signed [11:0] cos_v;
	logic signed [11:0] sin_v;
	logic signed [25:0] amp_add;
	logic sync_hit;
	logic lfsr_fb;

	assign hp_mode = (s_r.path_mode == `MODE_HIGH_PERF);
	assign fixed_nco = !hp_mode && s_r.ll_sel[`LL_SEL_BIT];
	assign eff_freq = fixed_nco ? `FS4_WORD : s_r.freq;
	assign dith_phase = s_r.dither[`DITH_PHASE_BIT] ? {6'h00, s_r.lfsr[9:0], 16'h0000} : 32'h0;
	assign ph_sum = s_r.acc + dith_phase;
	assign cos_v = sine6(ph_sum[31:26] + 6'h10);
	assign sin_v = sine6(ph_sum[31:26]);
	// Random rounding offset spreads the quantisation error into noise
	assign amp_add = s_r.dither[`DITH_AMP_BIT] ? $signed({15'h0000, s_r.lfsr[15:5]})
		: 26'sh0000400;
	assign lfsr_fb = s_r.lfsr[15] ^ s_r.lfsr[14] ^ s_r.lfsr[12] ^ s_r.lfsr[3];
	assign sync_hit = s_r.sync_s2 && !s_r.sync_d && s_r.sync_ctl[`SYNC_EN_BIT]
		&& (s_r.sync_ctl[`SYNC_EVERY_BIT] || s_r.armed);

	// ----------------------------------------
	// Per-channel mixer and filter
	// ----------------------------------------
	logic [1:0][13:0] x_sat;
	logic [1:0] ovr_raw;
	logic [1:0][1:0][13:0] mix;
	logic [1:0][1:0][13:0] fir_v;

	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic signed [25:0] pc;
		logic signed [25:0] ps;
		assign ovr_raw[c] = ($signed(samples_i[c]) > `IN_POS_FULL)
			|| ($signed(samples_i[c]) < `IN_NEG_FULL);
		assign x_sat[c] = sat14({{3{samples_i[c][15]}}, samples_i[c]});
		assign pc = $signed(x_sat[c]) * cos_v + amp_add;
		assign ps = $signed(x_sat[c]) * sin_v + amp_add;
		assign mix[c][0] = pc[24:11];
		assign mix[c][1] = 14'(-$signed(ps[24:11]));
		assign fir_v[c][0] = fir(hp_mode, mix[c][0], s_r.hist[c][0]);
		assign fir_v[c][1] = fir(hp_mode, mix[c][1], s_r.hist[c][1]);
	end

	// ----------------------------------------
	// fs/4 real output and coding
	// ----------------------------------------
	logic ch_sel;
	logic [13:0] real_w;
	logic [13:0] coded_w;

	assign ch_sel = !s_r.data_capture_clock_out;
	always_comb begin
		case (s_r.fs4_cnt)
			2'd0: real_w = s_r.filt[ch_sel][0];
			2'd1: real_w = sat14(-$signed({{5{s_r.filt[ch_sel][1][13]}}, s_r.filt[ch_sel][1]}));
			2'd2: real_w = sat14(-$signed({{5{s_r.filt[ch_sel][0][13]}}, s_r.filt[ch_sel][0]}));
			default: real_w = s_r.filt[ch_sel][1];
		endcase
	end
	assign coded_w = s_r.out_fmt[`FMT_OFFSET_BIN_BIT] ? {~real_w[13], real_w[12:0]}
		: real_w;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = 8'h00;
		// Register writes
		if (bus_i.wr) begin
			if (bus_i.addr == `OFS_PATH_MODE) begin
				s_nxt.path_mode = bus_i.wdata;
			end else if (bus_i.addr == `OFS_DITHER) begin
				s_nxt.dither = bus_i.wdata;
			end else if (bus_i.addr == `OFS_FREQ0) begin
				s_nxt.freq[7:0] = bus_i.wdata;
			end else if (bus_i.addr == `OFS_FREQ1) begin
				s_nxt.freq[15:8] = bus_i.wdata;
			end else if (bus_i.addr == `OFS_FREQ2) begin
				s_nxt.freq[23:16] = bus_i.wdata;
			end else if (bus_i.addr == `OFS_FREQ3) begin
				s_nxt.freq[31:24] = bus_i.wdata;
			end else if (bus_i.addr == `OFS_PHASE_LO) begin
				s_nxt.phase_ofs[7:0] = bus_i.wdata;
			end else if (bus_i.addr == `OFS_PHASE_HI) begin
				s_nxt.phase_ofs[15:8] = bus_i.wdata;
			end else if (bus_i.addr == `OFS_SYNC_CTL) begin
				s_nxt.sync_ctl = bus_i.wdata;
			end else if (bus_i.addr == `OFS_LL_SELECT) begin
				s_nxt.ll_sel = bus_i.wdata;
			end else if (bus_i.addr == `OFS_OUT_FORMAT) begin
				s_nxt.out_fmt = bus_i.wdata;
			end
		end
		// Register reads, unmapped reads as zero
		if (bus_i.rd) begin
			if (bus_i.addr == `OFS_PATH_MODE) begin
				s_nxt.rdata = s_r.path_mode;
			end else if (bus_i.addr == `OFS_DITHER) begin
				s_nxt.rdata = s_r.dither;
			end else if (bus_i.addr == `OFS_FREQ0) begin
				s_nxt.rdata = s_r.freq[7:0];
			end else if (bus_i.addr == `OFS_FREQ1) begin
				s_nxt.rdata = s_r.freq[15:8];
			end else if (bus_i.addr == `OFS_FREQ2) begin
				s_nxt.rdata = s_r.freq[23:16];
			end else if (bus_i.addr == `OFS_FREQ3) begin
				s_nxt.rdata = s_r.freq[31:24];
			end else if (bus_i.addr == `OFS_PHASE_LO) begin
				s_nxt.rdata = s_r.phase_ofs[7:0];
			end else if (bus_i.addr == `OFS_PHASE_HI) begin
				s_nxt.rdata = s_r.phase_ofs[15:8];
			end else if (bus_i.addr == `OFS_SYNC_CTL) begin
				s_nxt.rdata = s_r.sync_ctl;
			end else if (bus_i.addr == `OFS_LL_SELECT) begin
				s_nxt.rdata = s_r.ll_sel;
			end else if (bus_i.addr == `OFS_OUT_FORMAT) begin
				s_nxt.rdata = s_r.out_fmt;
			end else if (bus_i.addr == `OFS_STATUS) begin
				s_nxt.rdata = {5'h00, s_r.ovr_out, s_r.armed};
			end
		end
		// Sync pin: two flops, then edge detect on the second
		s_nxt.sync_s1 = sync_i;
		s_nxt.sync_s2 = s_r.sync_s1;
		s_nxt.sync_d = s_r.sync_s2;
		// Rewrite re-arms; wins over the clear of the same cycle
		if (sync_hit) begin
			s_nxt.armed = 1'b0;
		end
		if (bus_i.wr && bus_i.addr == `OFS_SYNC_CTL) begin
			s_nxt.armed = 1'b1;
		end
		// Phase accumulator never stops
		if (sync_hit) begin
			s_nxt.acc = {s_r.phase_ofs, 16'h0000};
		end else begin
			s_nxt.acc = s_r.acc + eff_freq;
		end
		s_nxt.lfsr = {s_r.lfsr[14:0], lfsr_fb};
		for (int c = 0; c < 2; c++) begin
			s_nxt.ovr_pipe[c] = {s_r.ovr_pipe[c][7:0], ovr_raw[c]};
			s_nxt.ovr_out[c] = s_r.ovr_pipe[c][8];
			for (int q = 0; q < 2; q++) begin
				s_nxt.hist[c][q] = {s_r.hist[c][q][2:0], mix[c][q]};
				s_nxt.filt[c][q] = fir_v[c][q];
			end
		end
		s_nxt.fs4_cnt = s_r.fs4_cnt + 2'd1;
		// Channels interleave: B with the clock high, A with it low
		s_nxt.data_capture_clock_out = !s_r.data_capture_clock_out;
		s_nxt.dout = coded_w;
		if (s_r.up_cnt != 4'hf) begin
			s_nxt.up_cnt = s_r.up_cnt + 4'h1;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			s_r <= '0;
			s_r.path_mode <= `RST_PATH_MODE;
			s_r.ll_sel <= `RST_LL_SELECT;
			s_r.out_fmt <= `RST_ZERO8;
			s_r.lfsr <= `LFSR_SEED;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata_o = s_r.rdata;
	assign data_o = s_r.dout;
	assign data_capture_clock_out_o = s_r.data_capture_clock_out;
	assign overrange_o = s_r.ovr_out;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	property p_ovr_latency;
		(s_r.up_cnt >= 4'd11) |-> overrange_o[0] == $past(ovr_raw[0], 10);
	endproperty
	a_ovr_latency: assert property (p_ovr_latency) else $error("overrange delay wrong");

	property p_offset_bin;
		$past(s_r.out_fmt[0]) && s_r.up_cnt > 4'd1
			|-> data_o == {~$past(real_w[13]), $past(real_w[12:0])};
	endproperty
	a_offset_bin: assert property (p_offset_bin) else $error("offset binary coding wrong");

	property p_saturate;
		($signed(samples_i[1]) > `IN_POS_FULL) |-> x_sat[1] == `OUT_POS_FULL;
	endproperty
	a_saturate: assert property (p_saturate) else $error("positive saturation wrong");

	property p_twos_default;
		$rose(rstn_i) |-> s_r.out_fmt == 8'h00 ##1 !$past(s_r.out_fmt[0]);
	endproperty
	a_twos_default: assert property (p_twos_default) else $error("default coding wrong");

	property p_dco_toggle;
		s_r.up_cnt > 4'd0 |-> ##1 data_capture_clock_out_o != $past(data_capture_clock_out_o);
	endproperty
	a_dco_toggle: assert property (p_dco_toggle) else $error("data clock stalled");

	property p_acc_step;
		rstn_i && !sync_hit |=> s_r.acc == $past(s_r.acc) + $past(eff_freq);
	endproperty
	a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong");

	property p_freq_byte3;
		bus_i.wr && bus_i.addr == `OFS_FREQ3 |=> s_r.freq[31:24] == $past(bus_i.wdata);
	endproperty
	a_freq_byte3: assert property (p_freq_byte3) else $error("frequency byte not stored");

	property p_first_only;
		sync_hit && !s_r.sync_ctl[1] && !bus_i.wr ##1 (!sync_hit && !bus_i.wr)[*3] |-> !s_r.armed;
	endproperty
	a_first_only: assert property (p_first_only) else $error("first-only sync re-armed");

	property p_sync_reload;
		sync_hit |=> s_r.acc == {$past(s_r.phase_ofs), 16'h0000};
	endproperty
	a_sync_reload: assert property (p_sync_reload) else $error("sync reload wrong");

	property p_fixed_fs4;
		s_r.path_mode == `MODE_LOW_LATENCY && s_r.ll_sel[0] |-> eff_freq == `FS4_WORD;
	endproperty
	a_fixed_fs4: assert property (p_fixed_fs4) else $error("fixed NCO not at fs/4");

	property p_fs4_step;
		s_r.fs4_cnt == 2'd3 |=> s_r.fs4_cnt == 2'd0 ##1 s_r.fs4_cnt == 2'd1;
	endproperty
	a_fs4_step: assert property (p_fs4_step) else $error("fs/4 phase wrong");

	property p_seed;
		$rose(rstn_i) |-> s_r.lfsr == `LFSR_SEED;
	endproperty
	a_seed: assert property (p_seed) else $error("dither seed wrong");

	c_sync: cover property (sync_hit ##1 s_r.acc == {s_r.phase_ofs, 16'h0000});
	c_ovr: cover property ($rose(overrange_o[0]));
	c_hp_dither: cover property (hp_mode && s_r.dither[1] && s_r.dither[2]);
	c_offset_bin: cover property (s_r.out_fmt[0] && data_o == 14'h2000);

endmodule : ddc_nco_path
`default_nettype wire

//--- rtl/ddc_pkg.sv
// Types shared by the downconversion path
package ddc_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] path_mode;
		logic [7:0] dither;
		logic [31:0] freq;
		logic [15:0] phase_ofs;
		logic [7:0] sync_ctl;
		logic [7:0] ll_sel;
		logic [7:0] out_fmt;
		logic [7:0] rdata;
		logic armed;
		logic sync_s1;
		logic sync_s2;
		logic sync_d;
		logic [31:0] acc;
		logic [15:0] lfsr;
		logic [1:0][8:0] ovr_pipe;
		logic [1:0][1:0][3:0][13:0] hist;
		logic [1:0][1:0][13:0] filt;
		logic [1:0] fs4_cnt;
		logic [13:0] dout;
		logic [1:0] ovr_out;
		logic data_capture_clock_out;
		logic [3:0] up_cnt;
	} state_t;
endpackage : ddc_pkg

//--- test/capture_model.sv
// Behavioural capture register that latches output words on both data clock edges
`timescale 1ns/10ps
`default_nettype none
module capture_model (
	input wire logic dco_i,
	input wire logic [13:0] data_i,
	output logic [13:0] word_a_o,
	output logic [13:0] word_b_o
);
	// ----------------------------------------
	// Capture
	// ----------------------------------------
	// Clock and data leave the same flop, so sample a quarter sample clock period later
	always @(posedge dco_i) #5 word_a_o <= data_i;
	always @(negedge dco_i) #5 word_b_o <= data_i;
endmodule : capture_model
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for registers, sync arming, overrange delay and output coding
`timescale 1ns/10ps
`default_nettype none
`include "ddc_consts.svh"
module tb_top;
	import ddc_pkg::*;
	typedef struct {
		time due;
		logic [1:0] kind;
		logic [27:0] exp;
	} note_t;
	logic ref_clk_i;
	logic rstn_i;
	reg_req_t bus_i;
	logic [7:0] rdata_o;
	logic [1:0][15:0] samples_i;
	logic sync_i;
	logic [13:0] data_o;
	logic data_capture_clock_out;
	logic [1:0] overrange_o;
	logic [13:0] word_a;
	logic [13:0] word_b;
	note_t notes[$];
	note_t n;
	logic [27:0] got;
	logic [31:0] seed;
	logic [31:0] v;
	logic [15:0] edge_vals[7] = '{16'h1fff, 16'h2000, 16'he000, 16'hdfff, 16'h7fff, 16'h8000, 16'h0000};
	int n_mismatch;
	int checks;
	// ----------------------------------------
	// Design and capture partner
	// ----------------------------------------
	ddc_nco_path u_ddc_nco_path (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .bus_i(bus_i),
		.rdata_o(rdata_o), .samples_i(samples_i), .sync_i(sync_i), .data_o(data_o),
		.data_capture_clock_out_o(data_capture_clock_out), .overrange_o(overrange_o));
	capture_model u_capture_model (.dco_i(data_capture_clock_out), .data_i(data_o), .word_a_o(word_a),
		.word_b_o(word_b));
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xorshift
	function automatic logic oor(input logic [15:0] s);
		return $signed(s) > `IN_POS_FULL || $signed(s) < `IN_NEG_FULL;
	endfunction : oor
	// Read notes fall due in the cycle after the strobe, sampled mid-cycle
	task automatic bus_op(input logic is_rd, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		bus_i <= '{addr: a, wdata: is_rd ? 8'h00 : d, wr: !is_rd, rd: is_rd};
		if (is_rd) notes.push_back('{$time + 30, 2'd0, {20'h0, d}});
		@(posedge ref_clk_i);
		bus_i.wr <= 1'b0;
		bus_i.rd <= 1'b0;
	endtask : bus_op
	task automatic drive(input logic [15:0] s0, input logic [15:0] s1);
		@(posedge ref_clk_i);
		samples_i <= {s1, s0};
		notes.push_back('{$time + 210, 2'd1, {26'h0, oor(s1), oor(s0)}});
	endtask : drive
	// Earlier overrange notes fall due later, so let them drain first
	task automatic check_words(input logic [13:0] w);
		while (notes.size() > 0) @(posedge ref_clk_i);
		@(posedge ref_clk_i);
		notes.push_back('{$time + 10, 2'd2, {w, w}});
	endtask : check_words
	// Sync held for one link period, 8 sample clocks
	task automatic pulse_sync();
		@(posedge ref_clk_i);
		sync_i <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		sync_i <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
	endtask : pulse_sync
	task automatic do_reset();
		repeat (12) @(posedge ref_clk_i);
		rstn_i <= 1'b0;
		repeat (10) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
	endtask : do_reset
	task automatic finish_test();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	// ----------------------------------------
	// Output monitor
	// ----------------------------------------
	always @(negedge ref_clk_i) begin
		while (notes.size() > 0 && notes[0].due <= $time) begin
			n = notes.pop_front();
			got = (n.kind == 2'd0) ? {20'h0, rdata_o} :
				(n.kind == 2'd1) ? {26'h0, overrange_o} : {word_a, word_b};
			checks++;
			if (got !== n.exp) begin
				n_mismatch++;
				$display("ERROR t=%0t exp=%h got=%h", $time, n.exp, got);
			end
		end
	end
	initial begin
		#100us;
		n_mismatch++;
		finish_test();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		bus_i = '0;
		samples_i = '0;
		sync_i = 1'b0;
		rstn_i = 1'b0;
		n_mismatch = 0;
		checks = 0;
		seed = 32'd44;
		repeat (10) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		bus_op(1, `OFS_PATH_MODE, `RST_PATH_MODE);
		bus_op(1, `OFS_LL_SELECT, `RST_LL_SELECT);
		bus_op(1, `OFS_OUT_FORMAT, 8'h00);
		for (int a = 'h51; a <= 'h58; a++) bus_op(1, a[7:0], 8'h00);
		bus_op(1, 8'h40, 8'h00);
		$display("test reset_values done");
		// Random tuning words are legal only in the tunable mode
		bus_op(0, `OFS_PATH_MODE, `MODE_HIGH_PERF);
		bus_op(1, `OFS_PATH_MODE, `MODE_HIGH_PERF);
		for (int a = 'h51; a <= 'h57; a++) begin
			v = xorshift();
			bus_op(0, a[7:0], v[7:0]);
			bus_op(1, a[7:0], v[7:0]);
		end
		// Quarter-rate carrier word from carrier and sample rate
		v = 32'((64'h100000000 * (64'd61440 % 64'd245760)) / 64'd245760);
		for (int b = 0; b < 4; b++) bus_op(0, 8'(`OFS_FREQ0 + b), v[8*b +: 8]);
		bus_op(1, `OFS_FREQ3, 8'(`FS4_WORD >> 24));
		bus_op(0, `OFS_PATH_MODE, `MODE_LOW_LATENCY);
		bus_op(1, `OFS_PATH_MODE, `MODE_LOW_LATENCY);
		$display("test register_access done");
		// Disabled sync leaves the write-armed flag standing
		bus_op(0, `OFS_SYNC_CTL, 8'h00);
		pulse_sync();
		bus_op(1, `OFS_STATUS, 8'h01);
		bus_op(0, `OFS_SYNC_CTL, 8'h01);
		bus_op(1, `OFS_SYNC_CTL, 8'h01);
		bus_op(1, `OFS_STATUS, 8'h01);
		pulse_sync();
		bus_op(1, `OFS_STATUS, 8'h00);
		bus_op(0, `OFS_SYNC_CTL, 8'h03);
		pulse_sync();
		bus_op(1, `OFS_STATUS, 8'h00);
		$display("test sync_policy done");
		foreach (edge_vals[i]) drive(edge_vals[i], ~edge_vals[i]);
		repeat (200) begin
			v = xorshift();
			drive(v[15:0], v[31:16]);
		end
		repeat (12) drive(16'h0000, 16'h0000);
		$display("test overrange done");
		do_reset();
		repeat (40) drive(16'h0000, 16'h0000);
		check_words(14'h0000);
		bus_op(0, `OFS_OUT_FORMAT, 8'h01);
		repeat (20) drive(16'h0000, 16'h0000);
		check_words(14'h2000);
		repeat (12) @(posedge ref_clk_i);
		$display("test output_coding done");
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
